// ==== src/adc_gain_pkg.sv ====
/*
 * Constants, register map and state type for the selectable-gain
 * converter control block.
 * Assumes a single 10 MHz system clock and a plain register port.
 */
package adc_gain_pkg;

	// register offsets
	localparam logic [7:0] GAIN_HIGH_OFS = 8'h00;
	localparam logic [7:0] GAIN_LOW_OFS = 8'h01;
	localparam logic [7:0] FINE_ADD_OFS = 8'h02;
	localparam logic [7:0] CTRL_OFS = 8'h03;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] RESULT_LOW_OFS = 8'h05;
	localparam logic [7:0] RESULT_HIGH_OFS = 8'h06;

	// field positions
	localparam int FINE_BIT = 0;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_DONE_CLR_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;

	// reset values
	localparam logic [7:0] GAIN_HIGH_RST = 8'hfc;
	localparam logic [7:0] GAIN_LOW_RST = 8'h00;
	localparam logic FINE_ADD_RST = 1'b1;
	localparam logic [11:0] UNITY_GAIN_WORD = 12'hfc0;

	// gain arithmetic: word over 4096, fine step is 64/4096
	localparam int GAIN_FRAC_BITS = 12;
	localparam int FINE_SHIFT = 6;
	localparam logic [11:0] RESULT_MAX = 12'hfff;

	// timing: converter clock derived from the system clock
	localparam int SYS_CLK_HZ = 10_000_000;
	localparam int SAR_CLK_MAX_HZ = 3_600_000;
	localparam int SAR_DIV_MIN = (SYS_CLK_HZ + SAR_CLK_MAX_HZ - 1)
		/ SAR_CLK_MAX_HZ;
	// comparator passes two sync flops, so a period needs four cycles
	localparam int SAR_DIV = (SAR_DIV_MIN < 4) ? 4 : SAR_DIV_MIN;
	localparam int SAR_PERIODS = 13;
	localparam int EDGE_CYCLES = 2;
	localparam int CONV_CYCLES = SAR_PERIODS * SAR_DIV + EDGE_CYCLES;

	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_START,
		CONV_SAR,
		CONV_FINISH
	} conv_state_t;

endpackage

// ==== src/scale_if.sv ====
/*
 * Carrier between the sequencer and the gain scaler.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps
interface scale_if (
	input wire logic clk,
	input wire logic rst_n
);
	logic [11:0] raw;
	logic [11:0] gain_word;
	logic fine;
	logic [11:0] scaled;

	modport scaler (input clk, input rst_n, input raw, input gain_word,
		input fine, output scaled);
	modport user (input scaled, output raw, output gain_word,
		output fine);
endinterface

// ==== src/gain_scaler.sv ====
/*
 * Gain scaler: multiplies a raw 12-bit code by the programmed gain.
 * Assumes its inputs are stable registers; output is combinational
 * and is registered by the sequencer.
 */
`timescale 1ns/100ps
module gain_scaler (
	scale_if.scaler s
);
	logic [24:0] base_prod;
	logic [24:0] fine_prod;
	logic [24:0] total;
	logic [12:0] quot;

	// raw*word plus raw*64 when fine is on, then drop 12 fraction bits
	assign base_prod = 25'(s.raw) * 25'(s.gain_word);
	assign fine_prod = s.fine ? (25'(s.raw) << adc_gain_pkg::FINE_SHIFT)
		: 25'h0;
	assign total = base_prod + fine_prod;
	assign quot = total[24:adc_gain_pkg::GAIN_FRAC_BITS];
	// clamp rather than wrap: the top gain 1.015 can overrun 12 bits
	assign s.scaled = quot[12] ? adc_gain_pkg::RESULT_MAX
		: quot[11:0];

	a_result_clamp: assert property (
		@(posedge s.clk) disable iff (!s.rst_n)
		(total >= 25'h1000000) |-> (s.scaled == 12'hfff))
		else $error("scaled result wrapped instead of clamping");
endmodule

// ==== src/adc_selectable_gain.sv ====
/*
 * Selectable-gain converter control: gain registers, conversion
 * sequencer driving a successive-approximation trial code, and
 * gain scaling of the finished code.
 * Assumes a comparator pin that is high while the input is above the
 * trial code, and a register master on ref_clk.
 */
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module adc_selectable_gain (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// conversion trigger from logic on ref_clk
	input wire logic conv_start,
	// analog front end
	input wire logic comp_in,
	output logic [11:0] dac_code,
	output logic track_hold,
	// conversion results
	output logic conv_busy,
	output logic conv_done,
	output logic [11:0] conv_result
);
	logic rst_meta_q, rst_n_q;
	logic comp_meta_q, comp_q;
	logic [7:0] gain_high_q, gain_low_q, reg_rdata_q;
	logic fine_q, done_flag_q, busy_q, hold_q, conv_done_q;
	adc_gain_pkg::conv_state_t state_q, state_d;
	logic [1:0] div_q;
	logic [3:0] period_q;
	logic [11:0] trial_q, trial_d, cur_bit, kept, result_q;
	logic [7:0] cyc_q;
	logic [11:0] gain_word;
	logic wr_high, wr_low, wr_fine, wr_ctrl, go, period_end, last_period;
	logic [7:0] rdata_d;
	logic [24:0] exact_num;

	scale_if sif (.clk(ref_clk), .rst_n(rst_n_q));

	gain_scaler u_scaler (.s(sif.scaler));

	// reset release through two flops
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// comparator pin comes from the analog side: two flops first
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			comp_meta_q <= 1'b0;
			comp_q <= 1'b0;
		end else begin
			comp_meta_q <= comp_in;
			comp_q <= comp_meta_q;
		end
	end

	// write decode
	assign wr_high = reg_wr && reg_addr == adc_gain_pkg::GAIN_HIGH_OFS;
	assign wr_low = reg_wr && reg_addr == adc_gain_pkg::GAIN_LOW_OFS;
	assign wr_fine = reg_wr && reg_addr == adc_gain_pkg::FINE_ADD_OFS;
	assign wr_ctrl = reg_wr && reg_addr == adc_gain_pkg::CTRL_OFS;
	// a start while busy is dropped, never queued
	assign go = state_q == adc_gain_pkg::CONV_IDLE && (conv_start ||
		(wr_ctrl && reg_wdata[adc_gain_pkg::CTRL_START_BIT]));

	// gain registers
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			gain_high_q <= adc_gain_pkg::GAIN_HIGH_RST;
			gain_low_q <= adc_gain_pkg::GAIN_LOW_RST;
			fine_q <= adc_gain_pkg::FINE_ADD_RST;
		end else begin
			if (wr_high)
				gain_high_q <= reg_wdata;
			if (wr_low)
				gain_low_q <= reg_wdata;
			if (wr_fine)
				fine_q <= reg_wdata[adc_gain_pkg::FINE_BIT];
		end
	end

	// only the upper nibble of the low register counts
	assign gain_word = {gain_high_q, gain_low_q[7:4]};
	assign sif.gain_word = gain_word;
	assign sif.fine = fine_q;
	assign sif.raw = trial_q;

	// read mux; unmapped offsets read zero
	always_comb begin
		case (reg_addr)
			adc_gain_pkg::GAIN_HIGH_OFS: rdata_d = gain_high_q;
			adc_gain_pkg::GAIN_LOW_OFS: rdata_d = gain_low_q;
			adc_gain_pkg::FINE_ADD_OFS: rdata_d = {7'h00, fine_q};
			adc_gain_pkg::STATUS_OFS: rdata_d = {6'h00, done_flag_q, busy_q};
			adc_gain_pkg::RESULT_LOW_OFS: rdata_d = result_q[7:0];
			adc_gain_pkg::RESULT_HIGH_OFS: rdata_d = {4'h0, result_q[11:8]};
			default: rdata_d = 8'h00;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q)
			reg_rdata_q <= 8'h00;
		else
			reg_rdata_q <= reg_rd ? rdata_d : 8'h00;
	end

	// sequencer: one start cycle, 13 converter periods, one finish cycle
	always_comb begin
		state_d = state_q;
		case (state_q)
			adc_gain_pkg::CONV_IDLE: begin
				if (go)
					state_d = adc_gain_pkg::CONV_START;
			end
			adc_gain_pkg::CONV_START: state_d = adc_gain_pkg::CONV_SAR;
			adc_gain_pkg::CONV_SAR: begin
				if (period_end && last_period)
					state_d = adc_gain_pkg::CONV_FINISH;
			end
			adc_gain_pkg::CONV_FINISH: state_d = adc_gain_pkg::CONV_IDLE;
			default: state_d = adc_gain_pkg::CONV_IDLE;
		endcase
	end

	// converter clock is ref_clk divided by SAR_DIV
	assign period_end = div_q == 2'(adc_gain_pkg::SAR_DIV - 1);
	assign last_period = period_q == 4'(adc_gain_pkg::SAR_PERIODS - 1);
	// trial bit of this period; last period only holds the code
	assign cur_bit = 12'h800 >> period_q;
	assign kept = comp_q ? trial_q : (trial_q & ~cur_bit);
	assign trial_d = kept | (cur_bit >> 1);

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= adc_gain_pkg::CONV_IDLE;
			div_q <= 2'h0;
			period_q <= 4'h0;
			trial_q <= 12'h000;
		end else begin
			state_q <= state_d;
			div_q <= (state_q == adc_gain_pkg::CONV_SAR && !period_end)
				? div_q + 2'h1 : 2'h0;
			if (state_q == adc_gain_pkg::CONV_START) begin
				period_q <= 4'h0;
				trial_q <= 12'h800;
			end else if (state_q == adc_gain_pkg::CONV_SAR && period_end) begin
				period_q <= period_q + 4'h1;
				// periods 0 to 11 each settle one bit, period 12 only holds
				if (!last_period)
					trial_q <= trial_d;
			end
		end
	end

	// result capture; done flag set wins over a same-cycle clear
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			result_q <= 12'h000;
			conv_done_q <= 1'b0;
			done_flag_q <= 1'b0;
			busy_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			conv_done_q <= state_q == adc_gain_pkg::CONV_FINISH;
			if (state_q == adc_gain_pkg::CONV_FINISH)
				result_q <= sif.scaled;
			if (state_q == adc_gain_pkg::CONV_FINISH)
				done_flag_q <= 1'b1;
			else if (wr_ctrl && reg_wdata[adc_gain_pkg::CTRL_DONE_CLR_BIT])
				done_flag_q <= 1'b0;
			busy_q <= state_d != adc_gain_pkg::CONV_IDLE;
			hold_q <= state_d == adc_gain_pkg::CONV_SAR;
		end
	end

	assign reg_rdata = reg_rdata_q;
	assign dac_code = trial_q;
	assign track_hold = hold_q;
	assign conv_busy = busy_q;
	assign conv_done = conv_done_q;
	assign conv_result = result_q;

	// helper logic for the checks below
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q)
			cyc_q <= 8'h00;
		else
			cyc_q <= state_q == adc_gain_pkg::CONV_IDLE ? 8'h00 : cyc_q + 8'h01;
	end
	assign exact_num = 25'(trial_q) * 25'(gain_word)
		+ (fine_q ? 25'(trial_q) * 25'h40 : 25'h0);

	sequence conv_go_s;
		state_q == adc_gain_pkg::CONV_IDLE && go;
	endsequence
	sequence in_finish_s;
		state_q == adc_gain_pkg::CONV_FINISH;
	endsequence

	a_gain_high_word: assert property (
		@(posedge ref_clk) disable iff (!rst_n_q)
		wr_high |=> gain_word[11:4] == $past(reg_wdata))
		else $error("gain word upper bits not from gain high");
	a_fine_bit_store: assert property (
		@(posedge ref_clk) disable iff (!rst_n_q)
		wr_fine |=> fine_q == $past(reg_wdata[0]))
		else $error("fine add bit not stored from bit zero");
	a_gain_scale_exact: assert property (
		@(posedge ref_clk) disable iff (!rst_n_q)
		in_finish_s |=> conv_done && (conv_result == 12'hfff ||
		((25'(conv_result) << 12) <= $past(exact_num) &&
		$past(exact_num) < ((25'(conv_result) + 25'h1) << 12))))
		else $error("result is not raw code times gain");
	a_reset_gain_unity: assert property (
		@(posedge ref_clk) disable iff (!rst_n_q)
		$rose(rst_n_q) |-> gain_high_q == 8'hfc && gain_low_q == 8'h00
		&& fine_q)
		else $error("gain registers wrong after reset");
	a_unity_passes_raw: assert property (
		@(posedge ref_clk) disable iff (!rst_n_q)
		in_finish_s ##0 (gain_word == adc_gain_pkg::UNITY_GAIN_WORD
		&& fine_q) |=> conv_result == $past(trial_q))
		else $error("unity gain changed the code");
	a_sar_periods: assert property (
		@(posedge ref_clk) disable iff (!rst_n_q)
		in_finish_s |-> period_q == 4'd13 && cyc_q == 8'd53)
		else $error("approximation did not span thirteen periods");
	a_conv_total: assert property (
		@(posedge ref_clk) disable iff (!rst_n_q)
		conv_go_s |-> ##1 conv_busy[*8] ##46 !conv_done ##1 conv_done)
		else $error("conversion did not take 54 cycles");
	a_done_flag_set: assert property (
		@(posedge ref_clk) disable iff (!rst_n_q)
		in_finish_s |=> done_flag_q)
		else $error("done flag lost against a clear");
endmodule

// ==== sim/adc_selectable_gain_test.sv ====
/*
 * Self-checking bench for the selectable-gain converter control block.
 * Assumes the register map and timing constants of adc_gain_pkg and a
 * comparator that follows the trial code within one cycle.
 */
`timescale 1ns/100ps
module adc_selectable_gain_test;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic conv_start = 1'b0;
	logic comp_in = 1'b0;
	logic [11:0] dac_code;
	logic track_hold;
	logic conv_busy;
	logic conv_done;
	logic [11:0] conv_result;
	logic [11:0] vin = 12'h000;
	int fail_count = 0;
	int cmp_count = 0;

	adc_selectable_gain DUT (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.conv_start(conv_start),
		.comp_in(comp_in),
		.dac_code(dac_code),
		.track_hold(track_hold),
		.conv_busy(conv_busy),
		.conv_done(conv_done),
		.conv_result(conv_result)
	);

	// 10 MHz system clock
	always #50 ref_clk = ~ref_clk;

	// comparator: input taken as vin plus half a step, so codes settle on vin
	always @(posedge ref_clk) comp_in <= (vin >= dac_code);

	task automatic check(input string what, input logic [11:0] exp,
		input logic [11:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe edge
	task automatic reg_check(input string what, input logic [7:0] a,
		input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		check(what, {4'h0, exp}, {4'h0, reg_rdata});
	endtask

	task automatic reset_values();
		reg_check("gain high rst", adc_gain_pkg::GAIN_HIGH_OFS, 8'hfc);
		reg_check("gain low rst", adc_gain_pkg::GAIN_LOW_OFS, 8'h00);
		reg_check("fine rst", adc_gain_pkg::FINE_ADD_OFS, 8'h01);
		@(posedge ref_clk);
		#1;
		check("rdata idle", 12'h000, {4'h0, reg_rdata});
		check("dac code rst", 12'h000, dac_code);
		check("result rst", 12'h000, conv_result);
		$display("test reset values done");
	endtask

	// program gain, convert vin, time it and check the scaled result
	task automatic convert(input logic [7:0] hi, input logic [7:0] lo,
		input logic fine, input logic [11:0] v, input logic by_reg);
		int n;
		int w;
		int e;
		w = {hi, lo[7:4]};
		e = (int'(v) * w + int'(fine) * int'(v) * 64) >> 12;
		if (e > 4095)
			e = 4095;
		reg_write(adc_gain_pkg::GAIN_HIGH_OFS, hi);
		reg_write(adc_gain_pkg::GAIN_LOW_OFS, lo);
		reg_write(adc_gain_pkg::FINE_ADD_OFS, {7'h00, fine});
		vin <= v;
		if (by_reg) begin
			reg_write(adc_gain_pkg::CTRL_OFS, 8'h01);
		end else begin
			@(posedge ref_clk);
			conv_start <= 1'b1;
			@(posedge ref_clk);
			conv_start <= 1'b0;
		end
		n = 0;
		while (n < 200) begin
			@(posedge ref_clk);
			n++;
			// a start while busy must be dropped without a trace
			conv_start <= (n == 10);
			#1;
			if (n == 30) begin
				check("busy mid", 12'h001, {11'h0, conv_busy});
				check("hold mid", 12'h001, {11'h0, track_hold});
			end
			if (conv_done === 1'b1)
				break;
		end
		check("cycles", 12'(adc_gain_pkg::CONV_CYCLES), 12'(n));
		check("busy at done", 12'h000, {11'h0, conv_busy});
		check("hold at done", 12'h000, {11'h0, track_hold});
		check("dac code", v, dac_code);
		check("result", 12'(e), conv_result);
		reg_check("res low", adc_gain_pkg::RESULT_LOW_OFS, 8'(e));
		reg_check("res high", adc_gain_pkg::RESULT_HIGH_OFS,
			{4'h0, 4'(e >> 8)});
		$display("test convert %h %h %b %h done", hi, lo, fine, v);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// watchdog: the tests need well under two thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		conclude();
	end

	initial begin
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		reset_values();
		convert(8'hfc, 8'h00, 1'b1, 12'habc, 1'b0);
		convert(8'h7c, 8'h00, 1'b1, 12'habc, 1'b1);
		convert(8'hbc, 8'h00, 1'b1, 12'h9f3, 1'b0);
		convert(8'h3c, 8'h00, 1'b1, 12'hfff, 1'b0);
		convert(8'hff, 8'hf0, 1'b0, 12'hfff, 1'b1);
		convert(8'hff, 8'hf0, 1'b1, 12'hfff, 1'b0);
		convert(8'hff, 8'hff, 1'b1, 12'hf00, 1'b0);
		convert(8'h6c, 8'ha0, 1'b1, 12'h800, 1'b0);
		convert(8'h6c, 8'ha0, 1'b0, 12'h800, 1'b1);
		convert(8'h00, 8'h00, 1'b0, 12'hfff, 1'b0);
		// status, readback masks and an unmapped place
		reg_check("status done", adc_gain_pkg::STATUS_OFS, 8'h02);
		reg_write(adc_gain_pkg::CTRL_OFS, 8'h02);
		reg_check("status clr", adc_gain_pkg::STATUS_OFS, 8'h00);
		reg_write(adc_gain_pkg::FINE_ADD_OFS, 8'hff);
		reg_check("fine mask", adc_gain_pkg::FINE_ADD_OFS, 8'h01);
		reg_write(8'h07, 8'hff);
		reg_check("unmapped", 8'h07, 8'h00);
		reg_check("ctrl reads 0", adc_gain_pkg::CTRL_OFS, 8'h00);
		$display("test registers done");
		// second reset in mid-run must restore unity gain
		reset_n <= 1'b0;
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		reset_values();
		conclude();
	end
endmodule
